// >>> common/ccl_cfg.svh
`ifndef CCL_CFG_SVH
`define CCL_CFG_SVH
`define CCL_PREAMBLE 4'h2
`define CCL_CHECK_CONST 4'h6
`define CCL_EXP_PREAMBLE 8'hF2
`define CCL_EXP_CHECK 8'hD2
`define CCL_EXP_START 8'hFE
`define CCL_LEN_BITS 24
`define CCL_CHK_BITS 4
`define CCL_RELEASE_CLKS 2'h2
`define CCL_REF_MHZ 100
`define CCL_SLOW_KHZ 1000
`define CCL_FAST_KHZ 8000
`define CCL_SLOW_HALF ((`CCL_REF_MHZ * 1000) / (2 * `CCL_SLOW_KHZ))
`define CCL_FAST_HALF ((`CCL_REF_MHZ * 1000) / (2 * `CCL_FAST_KHZ))
`endif

// >>> common/ccl_pkg.sv
package ccl_pkg;
    typedef enum logic [2:0] {
        CCL_IDLE = 3'b000,
        CCL_HEADER = 3'b001,
        CCL_FRAME = 3'b010,
        CCL_CHECK = 3'b011,
        CCL_FULL = 3'b100,
        CCL_DONE = 3'b101,
        CCL_ERROR = 3'b110
    } ccl_state_t;
endpackage : ccl_pkg

// >>> hdl/ccl_fifo.sv
`timescale 1ns/100ps
module ccl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic doWr;
    logic doRd;
    assign inReady = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;
    always_ff @(posedge ref_clk) begin
        if (doWr) begin
            mem[wrPtr_reg] <= inData;
        end
    end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doWr) begin
                wrPtr_reg <= AW'(wrPtr_reg + 1'b1);
            end
            if (doRd) begin
                rdPtr_reg <= AW'(rdPtr_reg + 1'b1);
            end
            count_reg <= (AW+1)'(count_reg + doWr - doRd);
        end
    end
endmodule : ccl_fifo

// >>> hdl/ccl_loader.sv
`timescale 1ns/100ps
`include "ccl_cfg.svh"
// What the document requires
// (R1) Pass header to chain output and capture length after the 0010 preamble.
// (R2) After the length field, hold chain output High until own frames done.
// (R3) Once full, forward all further start and data bits downstream.
// (R4) Count clocks after init; start up when count equals captured length.
// (R5) Serial mode releases user I/O two clocks after the final bit.
// (R6) Express mode takes one whole byte per configuration clock edge.
// (R7) Express checks constant field only, ignores length, waits for done High.
// (R8) Upper mode pin low selects Express whatever the lower pin.
// (R9) Source gives first byte before second edge, then one per edge.
// (R10) Express accepts frame data only with chain select High and not full.
// (R11) Express status output Low after header until full, then High.
// (R12) Undriven chain select is held High until configuration completes.
// (R13) Express activates only when open-drain done reads High; never drives High.
// (R14) Source waits until all init lines are High before sending.
// (R15) Master clock runs slow by default; a stream bit selects fast. Here the fastClockSelect pin, latched at start, selects it.
// (R16) Serial header: eight ones, preamble, 24-bit length, four ones.
// (R17) Serial frames open with zero bit, close with 4-bit check.
// (R18) Express uses byte preamble, check byte, start byte; bit 0 on line 0.
// (R19) Serial ends with postamble; don't-care start-up bytes follow.
// (R20) With CRC on, compare 4-bit partial check each frame end.
// (R21) On check error stop loading, pull init Low, keep master clock running.
// (R22) System restarts after error by reprogram pulse or power cycle.
// (R23) Express ignores length bits and holds status output Low.
// (R24) Mode pins sampled once at start; mode held until done or restart.
module ccl_loader
    import ccl_pkg::*;
#(
    parameter int FRAME_BITS = 127,
    parameter int FRAME_COUNT = 429,
    parameter int FRAME_BYTES = 16,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic configStart,
    input wire logic crcEnable,
    input wire logic fastClockSelect,
    input wire logic upper_mode_pin,
    input wire logic lower_mode_pin,
    input wire logic config_clock,
    input wire logic serialDataIn,
    input wire logic [7:0] config_byte_bus,
    input wire logic chain_select_input,
    input wire logic doneIn,
    input wire logic byteSinkReady,
    output logic chainDataOut,
    output logic initOutEn,
    output logic doneOutEn,
    output logic masterClockOut,
    output logic userIoActive,
    output logic expressMode,
    output logic memoryFull,
    output logic byteSinkValid,
    output logic [7:0] byteSinkData
);
    logic clkMeta_reg, clkSync_reg, clkLast_reg;
    logic dinMeta_reg, dinSync_reg, csMeta_reg, csSync_reg;
    logic doneMeta_reg, doneSync_reg;
    logic [7:0] busMeta_reg, busSync_reg;
    logic m1Meta_reg, m1Sync_reg;
    logic rise;
    ccl_state_t state_reg;
    logic express_reg, fast_reg, crcOn_reg;
    logic [`CCL_LEN_BITS-1:0] lenCount_reg, clkCount_reg;
    logic [7:0] shift_reg;
    logic [5:0] hdrBits_reg;
    logic [15:0] bitCnt_reg, frameCnt_reg;
    logic [3:0] crc_reg;
    logic [1:0] release_reg;
    logic fifoInReady, fifoOutValid;
    logic [7:0] fifoOutData;
    logic fifoPush;
    logic fifoTake;
    logic [15:0] halfCnt_reg;

    function automatic logic [3:0] crcStep(input logic [3:0] c,
                                           input logic d);
        logic fb;
        fb = c[3] ^ d;
        crcStep = {c[2], c[1] ^ fb, c[0], fb};
    endfunction : crcStep

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clkMeta_reg <= 1'b0;
            clkSync_reg <= 1'b0;
            clkLast_reg <= 1'b0;
            dinMeta_reg <= 1'b1;
            dinSync_reg <= 1'b1;
            csMeta_reg <= 1'b0;
            csSync_reg <= 1'b0;
            doneMeta_reg <= 1'b0;
            doneSync_reg <= 1'b0;
            busMeta_reg <= 8'h00;
            busSync_reg <= 8'h00;
            m1Meta_reg <= 1'b1;
            m1Sync_reg <= 1'b1;
        end else begin
            clkMeta_reg <= config_clock;
            clkSync_reg <= clkMeta_reg;
            clkLast_reg <= clkSync_reg;
            dinMeta_reg <= serialDataIn;
            dinSync_reg <= dinMeta_reg;
            csMeta_reg <= chain_select_input;
            csSync_reg <= csMeta_reg;
            doneMeta_reg <= doneIn;
            doneSync_reg <= doneMeta_reg;
            busMeta_reg <= config_byte_bus;
            busSync_reg <= busMeta_reg;
            m1Meta_reg <= upper_mode_pin;
            m1Sync_reg <= m1Meta_reg;
        end
    end
    // (R6) Sample on edge.
    assign rise = clkSync_reg && !clkLast_reg;
    // (R10) Accept gating.
    assign fifoPush = rise && express_reg && state_reg == CCL_FRAME
                      && csSync_reg && bitCnt_reg != '0
                      && bitCnt_reg <= 16'(FRAME_BYTES);
    // The output stage takes a byte when it is empty or when the sink takes the byte it holds.
    assign fifoTake = !byteSinkValid || byteSinkReady;

    // Frame bytes are buffered; a stalled sink stalls loading, not data.
    ccl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .inValid(fifoPush),
        .inReady(fifoInReady),
        .inData(busSync_reg),
        .outValid(fifoOutValid),
        .outReady(fifoTake),
        .outData(fifoOutData)
    );

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= CCL_IDLE;
            express_reg <= 1'b0;
            fast_reg <= 1'b0;
            crcOn_reg <= 1'b0;
            lenCount_reg <= '0;
            clkCount_reg <= '0;
            shift_reg <= 8'hFF;
            hdrBits_reg <= '0;
            bitCnt_reg <= '0;
            frameCnt_reg <= '0;
            crc_reg <= '0;
            release_reg <= '0;
            chainDataOut <= 1'b1;
            initOutEn <= 1'b0;
            userIoActive <= 1'b0;
        end else begin
            case (state_reg)
                CCL_IDLE: begin
                    if (configStart) begin
                        // (R8) (R24) Latch mode once.
                        express_reg <= !m1Sync_reg;
                        fast_reg <= fastClockSelect;
                        crcOn_reg <= crcEnable;
                        state_reg <= CCL_HEADER;
                        shift_reg <= 8'hFF;
                        hdrBits_reg <= '0;
                        clkCount_reg <= '0;
                        frameCnt_reg <= '0;
                        crc_reg <= '0;
                        chainDataOut <= m1Sync_reg;
                    end
                end
                CCL_HEADER: begin
                    if (rise) begin
                        clkCount_reg <= `CCL_LEN_BITS'(clkCount_reg + 1'b1);
                        shift_reg <= {shift_reg[6:0], dinSync_reg};
                        if (express_reg) begin
                            // (R18) (R23) Byte header, length ignored.
                            chainDataOut <= 1'b0;
                            if (busSync_reg == `CCL_EXP_CHECK) begin
                                state_reg <= CCL_FRAME;
                                bitCnt_reg <= '0;
                            end
                        end else begin
                            // (R1) Forward header downstream.
                            chainDataOut <= dinSync_reg;
                            if (hdrBits_reg == 6'h00) begin
                                // (R16) Preamble detect.
                                if ({shift_reg[2:0], dinSync_reg}
                                    == `CCL_PREAMBLE) begin
                                    hdrBits_reg <= 6'h01;
                                end
                            end else if (hdrBits_reg <= 6'd24) begin
                                lenCount_reg <= {lenCount_reg[22:0],
                                                 dinSync_reg};
                                hdrBits_reg <= 6'(hdrBits_reg + 1'b1);
                            end else if (hdrBits_reg < 6'd28) begin
                                hdrBits_reg <= 6'(hdrBits_reg + 1'b1);
                            end else if (!dinSync_reg) begin
                                // (R2) (R17) Frame start, hold High.
                                chainDataOut <= 1'b1;
                                state_reg <= CCL_FRAME;
                                bitCnt_reg <= '0;
                            end
                        end
                    end
                end
                CCL_FRAME: begin
                    if (rise) begin
                        clkCount_reg <= `CCL_LEN_BITS'(clkCount_reg + 1'b1);
                        if (!express_reg) begin
                            crc_reg <= crcStep(crc_reg, dinSync_reg);
                            chainDataOut <= 1'b1;
                            bitCnt_reg <= 16'(bitCnt_reg + 1'b1);
                            if (bitCnt_reg == 16'(FRAME_BITS - 6)) begin
                                state_reg <= CCL_CHECK;
                                hdrBits_reg <= '0;
                            end
                        end else if (csSync_reg && fifoInReady) begin
                            bitCnt_reg <= 16'(bitCnt_reg + 1'b1);
                            if (bitCnt_reg == '0 &&
                                busSync_reg != `CCL_EXP_START) begin
                                // (R18) Start byte check.
                                state_reg <= CCL_ERROR;
                            end else if (bitCnt_reg ==
                                         16'(FRAME_BYTES + 1)) begin
                                // (R7) Constant field check only.
                                if (busSync_reg != `CCL_EXP_CHECK) begin
                                    state_reg <= CCL_ERROR;
                                end else if (frameCnt_reg ==
                                             16'(FRAME_COUNT - 1)) begin
                                    state_reg <= CCL_FULL;
                                end else begin
                                    frameCnt_reg <= 16'(frameCnt_reg + 1'b1);
                                    bitCnt_reg <= '0;
                                end
                            end
                        end
                    end
                end
                CCL_CHECK: begin
                    if (rise) begin
                        clkCount_reg <= `CCL_LEN_BITS'(clkCount_reg + 1'b1);
                        shift_reg <= {shift_reg[6:0], dinSync_reg};
                        hdrBits_reg <= 6'(hdrBits_reg + 1'b1);
                        if (hdrBits_reg == 6'(`CCL_CHK_BITS - 1)) begin
                            // (R20) (R17) Compare check field.
                            if ({shift_reg[2:0], dinSync_reg} !=
                                (crcOn_reg ? crc_reg : `CCL_CHECK_CONST))
                            begin
                                state_reg <= CCL_ERROR;
                            end else if (frameCnt_reg ==
                                         16'(FRAME_COUNT - 1)) begin
                                state_reg <= CCL_FULL;
                            end else begin
                                frameCnt_reg <= 16'(frameCnt_reg + 1'b1);
                                state_reg <= CCL_FRAME;
                                // Next start bit wraps the count to zero.
                                bitCnt_reg <= '1;
                                crc_reg <= '0;
                            end
                        end
                    end
                end
                CCL_FULL: begin
                    // (R11) Status High once full.
                    if (express_reg) begin
                        chainDataOut <= 1'b1;
                        // (R13) Wait for wired done.
                        if (doneSync_reg) begin
                            state_reg <= CCL_DONE;
                        end
                    end else if (rise) begin
                        // (R3) Pass-through downstream.
                        chainDataOut <= dinSync_reg;
                        clkCount_reg <= `CCL_LEN_BITS'(clkCount_reg + 1'b1);
                        // (R4) Start-up at length count.
                        if (clkCount_reg == lenCount_reg) begin
                            state_reg <= CCL_DONE;
                            release_reg <= '0;
                        end
                    end
                end
                CCL_DONE: begin
                    if (express_reg) begin
                        userIoActive <= 1'b1;
                    end else if (rise) begin
                        // (R5) Release after two clocks.
                        if (release_reg == `CCL_RELEASE_CLKS - 2'h1) begin
                            userIoActive <= 1'b1;
                        end else begin
                            release_reg <= 2'(release_reg + 1'b1);
                        end
                    end
                end
                CCL_ERROR: begin
                    // (R21) Suspend and pull init Low.
                    initOutEn <= 1'b1;
                end
                default: begin
                    state_reg <= CCL_IDLE;
                end
            endcase
        end
    end

    // (R15) Master clock divider, keeps running after an error.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            halfCnt_reg <= '0;
            masterClockOut <= 1'b0;
        end else if (halfCnt_reg >= 16'((fast_reg ? `CCL_FAST_HALF
                                         : `CCL_SLOW_HALF) - 1)) begin
            halfCnt_reg <= '0;
            masterClockOut <= !masterClockOut;
        end else begin
            halfCnt_reg <= 16'(halfCnt_reg + 1'b1);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            doneOutEn <= 1'b1;
            expressMode <= 1'b0;
            memoryFull <= 1'b0;
            byteSinkValid <= 1'b0;
            byteSinkData <= 8'h00;
        end else begin
            // (R13) Done only ever pulled Low, released when full.
            doneOutEn <= !(state_reg == CCL_FULL || state_reg == CCL_DONE);
            expressMode <= express_reg;
            memoryFull <= (state_reg == CCL_FULL || state_reg == CCL_DONE);
            if (fifoTake) begin
                byteSinkValid <= fifoOutValid;
                byteSinkData <= fifoOutData;
            end
        end
    end
endmodule : ccl_loader

// >>> verification/ccl_loader_sva.sv
`timescale 1ns/100ps
module ccl_loader_chk (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic configStart,
    input wire logic doneIn,
    input wire logic chainDataOut,
    input wire logic initOutEn,
    input wire logic doneOutEn,
    input wire logic userIoActive,
    input wire logic expressMode,
    input wire logic memoryFull,
    input wire logic byteSinkValid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_full_status_high: assert property (
        expressMode && memoryFull |-> ##[0:3] chainDataOut)
        else $error("status output stays low after memory full");
    a_io_after_done: assert property (
        $rose(userIoActive) && expressMode |-> doneIn)
        else $error("user io active while done line low");
    a_done_release: assert property (
        $fell(doneOutEn) |-> memoryFull)
        else $error("done line released before memory full");
    a_mode_held: assert property (
        $changed(expressMode) |->
        $past(configStart) || $past(configStart, 2) || $past(configStart, 3))
        else $error("load mode changed outside a start");
    a_error_stuck: assert property (
        initOutEn |=> initOutEn && !userIoActive)
        else $error("error state left or user io activated");
    a_bytes_express: assert property (
        byteSinkValid |-> expressMode)
        else $error("byte output valid outside byte mode");
    a_header_status: assert property (
        $fell(chainDataOut) && expressMode |-> !memoryFull)
        else $error("status output fell while memory full");
    a_io_needs_full: assert property (
        $rose(userIoActive) |-> memoryFull && !initOutEn)
        else $error("user io active before load completed");
endmodule : ccl_loader_chk
bind ccl_loader ccl_loader_chk u_chk (.ref_clk, .sys_rst, .configStart,
    .doneIn, .chainDataOut, .initOutEn, .doneOutEn, .userIoActive,
    .expressMode, .memoryFull, .byteSinkValid);

// >>> verification/ccl_source.sv
`timescale 1ns/100ps
module ccl_source (
    output logic config_clock,
    output logic serialDataIn,
    output logic [7:0] config_byte_bus
);
    initial begin
        config_clock = 1'b0;
        serialDataIn = 1'b1;
        config_byte_bus = 8'hFF;
    end
    // data before edge.
    // The clock only runs inside a transfer and rests low between them.
    task automatic send(input logic [7:0] v);
        serialDataIn = v[0];
        config_byte_bus = v;
        #62.5 config_clock = 1'b1;
        #62.5 config_clock = 1'b0;
    endtask : send
endmodule : ccl_source

// >>> verification/chained_config_stream_loader_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin \
miscompares++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module chained_config_stream_loader_tb_top;
    localparam int LEN = 80;
    logic ref_clk, sys_rst, configStart, upper_mode_pin, lower_mode_pin;
    logic chain_select_input, doneIn, byteSinkReady;
    logic crcEnable, fastClockSelect;
    int hp;
    logic config_clock, serialDataIn;
    logic [7:0] config_byte_bus, byteSinkData;
    logic chainDataOut, initOutEn, doneOutEn, masterClockOut;
    logic userIoActive, expressMode, memoryFull, byteSinkValid;
    logic [7:0] rx[$];
    logic [7:0] hdr[6] = '{8'hFF, 8'hF2, 8'h00, 8'h00, 8'h50, 8'hD2};
    int miscompares;
    int totalChecks;
    always #5 ref_clk = ~ref_clk;
    ccl_source u_src (.config_clock, .serialDataIn, .config_byte_bus);
    // CRC stays off during loads: only the constant check is modelled.
    ccl_loader #(.FRAME_BITS(16), .FRAME_COUNT(2), .FRAME_BYTES(16),
        .FIFO_DEPTH(32)) DUT (.ref_clk, .sys_rst, .configStart,
        .crcEnable, .fastClockSelect, .upper_mode_pin,
        .lower_mode_pin, .config_clock, .serialDataIn, .config_byte_bus,
        .chain_select_input, .doneIn, .byteSinkReady, .chainDataOut,
        .initOutEn, .doneOutEn, .masterClockOut, .userIoActive,
        .expressMode, .memoryFull, .byteSinkValid, .byteSinkData);
    always @(posedge ref_clk) begin
        if (byteSinkValid === 1'b1 && byteSinkReady) rx.push_back(byteSinkData);
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic rst(input logic up, input logic lo);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        upper_mode_pin <= up;
        lower_mode_pin <= lo;
        doneIn <= 1'b0;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        `CHK("init", 1'b0, initOutEn)
        configStart <= 1'b1;
        @(posedge ref_clk);
        configStart <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : rst
    // Mode 0 expects pass-through, 1 a held high output, 2 no check.
    task automatic sbits(input logic [31:0] v, input int n, input int md);
        for (int i = n - 1; i >= 0; i--) begin
            u_src.send({7'h00, v[i]});
            if (md == 0) `CHK("pass", v[i], chainDataOut)
            if (md == 1) `CHK("hold", 1'b1, chainDataOut)
        end
    endtask : sbits
    task automatic shdr();
        sbits(32'hFF, 8, 0);
        sbits(32'h2, 4, 0);
        sbits(LEN, 24, 0);
        sbits(32'hF, 4, 0);
    endtask : shdr
    task automatic junk();
        @(posedge ref_clk);
        chain_select_input <= 1'b0;
        repeat (4) @(posedge ref_clk);
        repeat (3) u_src.send(8'h55);
        @(posedge ref_clk);
        chain_select_input <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask : junk
    task automatic halfp(output int n);
        logic v;
        v = masterClockOut;
        n = 0;
        while (masterClockOut === v && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
    endtask : halfp
    task automatic wt();
        int n;
        n = 0;
        while (userIoActive !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 2000) begin
            miscompares++;
            close_out();
        end
    endtask : wt
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        configStart = 1'b0;
        upper_mode_pin = 1'b1;
        lower_mode_pin = 1'b1;
        chain_select_input = 1'b1;
        doneIn = 1'b0;
        byteSinkReady = 1'b0;
        crcEnable = 1'b0;
        fastClockSelect = 1'b0;
        miscompares = 0;
        totalChecks = 0;
        for (int m = 0; m < 4; m++) begin
            fastClockSelect <= m[0];
            crcEnable <= m[0];
            rst(m[1], m[0]);
            `CHK("mode", ~m[1], expressMode)
            halfp(hp);
            halfp(hp);
            `CHK("clk rate", 1'b1, m[0] ? (hp >= 5 && hp <= 12) : (hp >= 40 && hp <= 100))
        end
        upper_mode_pin <= 1'b0;
        crcEnable <= 1'b0;
        fastClockSelect <= 1'b0;
        repeat (8) @(posedge ref_clk);
        `CHK("mode held", 1'b0, expressMode)
        $display("test mode done");
        rst(1'b1, 1'b1);
        shdr();
        repeat (2) sbits(32'h5556, 16, 1);
        `CHK("full", 1'b1, memoryFull)
        sbits(32'h7F, 8, 0);
        sbits(32'h3, 2, 2);
        `CHK("io early", 1'b0, userIoActive)
        sbits(32'h1, 1, 2);
        `CHK("io on", 1'b1, userIoActive)
        $display("test serial done");
        rst(1'b1, 1'b1);
        shdr();
        sbits(32'h555F, 16, 2);
        `CHK("error", 1'b1, initOutEn)
        sbits(32'hFFFF, 16, 2);
        `CHK("stopped", 1'b0, memoryFull)
        `CHK("io off", 1'b0, userIoActive)
        $display("test error done");
        rst(1'b0, 1'b1);
        foreach (hdr[k]) u_src.send(hdr[k]);
        `CHK("status", 1'b0, chainDataOut)
        for (int f = 0; f < 2; f++) begin
            u_src.send(8'hFE);
            if (f == 0) junk();
            for (int i = 0; i < 16; i++) u_src.send(8'(16 * f + i));
            u_src.send(8'hD2);
            `CHK("status", f[0], chainDataOut)
        end
        `CHK("full", 1'b1, memoryFull)
        repeat (4) u_src.send(8'hFF);
        `CHK("io early", 1'b0, userIoActive)
        @(posedge ref_clk);
        doneIn <= 1'b1;
        wt();
        byteSinkReady <= 1'b1;
        repeat (100) @(posedge ref_clk);
        `CHK("count", 32, rx.size())
        foreach (rx[k]) `CHK("byte", 8'(k), rx[k])
        $display("test express done");
        close_out();
    end
endmodule : chained_config_stream_loader_tb_top
